/* rtl/cas_exec_core.sv */
// Execution datapath for rotate, subtract, swap, xor, direction load and sleep.
// Assumes one Wishbone classic master; one command executes per bus write.
//
// How it works
// RULE1: Register operations take a 7-bit file address and a destination bit, 0 for work, 1 for file.
// RULE2: Rotate right moves the file byte down one bit through carry, touching only carry.
// RULE3: Literal subtract puts literal minus work into work and updates carry, digit carry and zero.
// RULE4: After literal subtract carry is 1 unless work exceeds literal, digit carry likewise per low nibble.
// RULE5: Register subtract writes file minus work to the chosen destination and updates three flags.
// RULE6: After register subtract carry and digit carry are 1 unless work exceeds the operand or its nibble.
// RULE7: Subtract with borrow also takes away the inverted carry and updates three flags.
// RULE8: Sleep clears the watchdog and its prescaler, sets timeout status and clears powerdown status.
// RULE9: Sleep halts execution with the oscillator stop output raised until software wakes the core.
// RULE10: Nibble swap exchanges the halves of the file byte into the destination with no flag change.
// RULE11: Direction load copies work into port A, B or C direction for operand 5, 6 or 7, else nothing.
// RULE12: Literal xor puts work xor literal into work and touches only zero.
// RULE13: Register xor writes work xor file byte to the destination and touches only zero.
// RULE14: Zero is set exactly when the eight-bit result is zero.
//
// Chosen here: the Wishbone interface to the registers and the register offsets.
`timescale 1ns/1ps

module cas_exec_core (
    input  wire logic                      mclk,
    input  wire logic                      rst,
    input  wire logic                      cyc,
    input  wire logic                      stb,
    input  wire logic                      we,
    input  wire logic [cas_pkg::ADR_W-1:0] adr,
    input  wire logic [3:0]                sel,
    input  wire logic [31:0]               datWr,
    output logic      [31:0]               datRd,
    output logic                           ack,
    output logic      [7:0]                portADirection,
    output logic      [7:0]                portBDirection,
    output logic      [7:0]                portCDirection,
    output logic                           oscStop
);
    import cas_pkg::*;

    ////////////////////////////////////////////////////////////////////////////////
    logic [7:0]  work_ff;
    logic        carry_ff;
    logic        digitCarryFlag_ff;
    logic        zero_ff;
    logic        timeoutStatusN_ff;
    logic        powerdownStatusN_ff;
    logic [7:0]  watchdogCounter_ff;
    logic [7:0]  prescaler_ff;
    logic [15:0] lastCmd_ff;
    logic [7:0]  dirA_ff;
    logic [7:0]  dirB_ff;
    logic [7:0]  dirC_ff;
    logic        ack_ff;
    logic [31:0] datRd_ff;
    cas_power_t  power_ff;
    logic [7:0]  fileMem [FILE_DEPTH];

    logic        take;
    logic        busWr;
    logic        fileHit;
    logic [6:0]  busIdx;
    logic        cmdFire;
    logic [3:0]  cmdOp;
    logic        cmdDest;
    logic [7:0]  cmdArg;
    logic [7:0]  fileVal;
    logic [8:0]  diff;
    logic [4:0]  nibDiff;
    logic        borrowIn;
    logic [7:0]  result;
    logic        nxt_carry;
    logic        nxt_digit;
    logic        updCarry;
    logic        updDigit;
    logic        updZero;
    logic        wrWork;
    logic        wrFile;
    logic        goSleep;
    logic [2:0]  dirWr;

    ////////////////////////////////////////////////////////////////////////////////
    // Bus decode; the access acts in the cycle ack is raised
    assign take    = cyc & stb & ~ack_ff;
    assign busWr   = take & we & sel[0];
    assign fileHit = (adr[ADR_W-1:9] == ADR_FILE_REGION);
    assign busIdx  = adr[8:2];
    // Commands are ignored while halted
    assign cmdFire = take & we & (sel[1:0] == 2'b11) & (adr == ADR_CMD)
                     & (power_ff == CAS_AWAKE);                              // [RULE9]
    assign cmdOp   = datWr[CMD_OP_LSB +: 4];
    assign cmdDest = datWr[CMD_DEST_BIT];                                   // [RULE1]
    assign cmdArg  = datWr[7:0];
    assign fileVal = fileMem[cmdArg[6:0]];                                  // [RULE1]

    ////////////////////////////////////////////////////////////////////////////////
    always_comb begin
        borrowIn  = 1'b0;
        result    = 8'h00;
        diff      = 9'h000;
        nibDiff   = 5'h00;
        nxt_carry = carry_ff;
        nxt_digit = digitCarryFlag_ff;
        updCarry  = 1'b0;
        updDigit  = 1'b0;
        updZero   = 1'b0;
        wrWork    = 1'b0;
        wrFile    = 1'b0;
        goSleep   = 1'b0;
        dirWr     = 3'b000;
        if (cmdFire) begin
            unique case (cmdOp)
                OP_ROTATE_RIGHT_CARRY: begin
                    result    = {carry_ff, fileVal[7:1]};                   // [RULE2]
                    nxt_carry = fileVal[0];                                 // [RULE2]
                    updCarry  = 1'b1;
                    wrWork    = ~cmdDest;
                    wrFile    = cmdDest;
                end
                OP_LITERAL_MINUS_WORK, OP_REG_MINUS_WORK, OP_REG_MINUS_WORK_BORROW: begin
                    // Borrow only for the borrow form; carry high means no borrow
                    borrowIn  = (cmdOp == OP_REG_MINUS_WORK_BORROW) ? ~carry_ff : 1'b0; // [RULE7]
                    if (cmdOp == OP_LITERAL_MINUS_WORK) begin
                        diff    = {1'b0, cmdArg} - {1'b0, work_ff};         // [RULE3]
                        nibDiff = {1'b0, cmdArg[3:0]} - {1'b0, work_ff[3:0]};
                    end else begin
                        diff    = {1'b0, fileVal} - {1'b0, work_ff} - {8'h00, borrowIn}; // [RULE5] [RULE7]
                        nibDiff = {1'b0, fileVal[3:0]} - {1'b0, work_ff[3:0]}
                                  - {4'h0, borrowIn};
                    end
                    result    = diff[7:0];
                    nxt_carry = ~diff[8];                                   // [RULE4] [RULE6]
                    nxt_digit = ~nibDiff[4];                                // [RULE4] [RULE6]
                    updCarry  = 1'b1;
                    updDigit  = 1'b1;
                    updZero   = 1'b1;
                    wrWork    = (cmdOp == OP_LITERAL_MINUS_WORK) | ~cmdDest; // [RULE3]
                    wrFile    = (cmdOp != OP_LITERAL_MINUS_WORK) & cmdDest;  // [RULE5]
                end
                OP_SLEEP: begin
                    goSleep = 1'b1;                                         // [RULE8] [RULE9]
                end
                OP_NIBBLE_SWAP: begin
                    result = {fileVal[3:0], fileVal[7:4]};                  // [RULE10]
                    wrWork = ~cmdDest;
                    wrFile = cmdDest;
                end
                OP_LOAD_PORT_DIRECTION: begin
                    // Any other operand is dropped silently
                    dirWr = {cmdArg == DIR_SEL_C, cmdArg == DIR_SEL_B,
                             cmdArg == DIR_SEL_A};                          // [RULE11]
                end
                OP_LITERAL_XOR: begin
                    result  = work_ff ^ cmdArg;                             // [RULE12]
                    updZero = 1'b1;
                    wrWork  = 1'b1;
                end
                OP_REG_XOR: begin
                    result  = work_ff ^ fileVal;                            // [RULE13]
                    updZero = 1'b1;
                    wrWork  = ~cmdDest;
                    wrFile  = cmdDest;
                end
                default: begin
                    result = 8'h00;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge mclk) begin
        if (rst) begin
            work_ff <= RST_WORK;
        end else if (wrWork) begin
            work_ff <= result;                                              // [RULE1]
        end else if (busWr && adr == ADR_WORK) begin
            work_ff <= datWr[7:0];
        end
    end

    // Flags: software writes never meet an execution in the same cycle
    always_ff @(posedge mclk) begin
        if (rst) begin
            carry_ff          <= 1'b0;
            digitCarryFlag_ff <= 1'b0;
            zero_ff           <= 1'b0;
        end else if (cmdFire) begin
            if (updCarry) begin
                carry_ff <= nxt_carry;                                      // [RULE2]
            end
            if (updDigit) begin
                digitCarryFlag_ff <= nxt_digit;
            end
            if (updZero) begin
                zero_ff <= (result == 8'h00);                               // [RULE14]
            end
        end else if (busWr && adr == ADR_STATUS) begin
            carry_ff          <= datWr[ST_CARRY];
            digitCarryFlag_ff <= datWr[ST_DIGIT];
            zero_ff           <= datWr[ST_ZERO];
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            timeoutStatusN_ff   <= 1'b1;
            powerdownStatusN_ff <= 1'b1;
        end else if (goSleep) begin
            timeoutStatusN_ff   <= 1'b1;                                    // [RULE8]
            powerdownStatusN_ff <= 1'b0;                                    // [RULE8]
        end
    end

    // Stand-in watchdog time base; it keeps counting in sleep
    always_ff @(posedge mclk) begin
        if (rst || goSleep) begin
            prescaler_ff       <= PRESCALER_CLR;                            // [RULE8]
            watchdogCounter_ff <= WATCHDOG_CLR;                             // [RULE8]
        end else begin
            prescaler_ff <= prescaler_ff + 8'h01;
            if (prescaler_ff == PRESCALER_TOP) begin
                watchdogCounter_ff <= watchdogCounter_ff + 8'h01;
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            power_ff <= CAS_AWAKE;
        end else begin
            unique case (power_ff)
                CAS_AWAKE: begin
                    if (goSleep) begin
                        power_ff <= CAS_ASLEEP;                             // [RULE9]
                    end
                end
                CAS_ASLEEP: begin
                    if (busWr && adr == ADR_WAKE && datWr[WAKE_BIT]) begin
                        power_ff <= CAS_AWAKE;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            dirA_ff <= RST_DIR;
            dirB_ff <= RST_DIR;
            dirC_ff <= RST_DIR;
        end else begin
            if (dirWr[0]) begin
                dirA_ff <= work_ff;                                         // [RULE11]
            end
            if (dirWr[1]) begin
                dirB_ff <= work_ff;
            end
            if (dirWr[2]) begin
                dirC_ff <= work_ff;
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            lastCmd_ff <= 16'h0000;
        end else if (cmdFire) begin
            lastCmd_ff <= datWr[15:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // File registers, one flip-flop byte per entry
    for (genvar i = 0; i < FILE_DEPTH; i++) begin : g_file
        always_ff @(posedge mclk) begin
            if (rst) begin
                fileMem[i] <= RST_FILE;
            end else if (wrFile && cmdArg[6:0] == 7'(i)) begin
                fileMem[i] <= result;                                       // [RULE1]
            end else if (busWr && fileHit && busIdx == 7'(i)) begin
                fileMem[i] <= datWr[7:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge mclk) begin
        if (rst) begin
            ack_ff   <= 1'b0;
            datRd_ff <= 32'h0000_0000;
        end else begin
            ack_ff <= take;
            if (take && !we) begin
                if (fileHit) begin
                    datRd_ff <= {24'h000000, fileMem[busIdx]};
                end else begin
                    unique case (adr)
                        ADR_CMD:      datRd_ff <= {16'h0000, lastCmd_ff};
                        ADR_WORK:     datRd_ff <= {24'h000000, work_ff};
                        ADR_STATUS:   datRd_ff <= {26'h0000000, power_ff == CAS_ASLEEP,
                                                   timeoutStatusN_ff, powerdownStatusN_ff,
                                                   zero_ff, digitCarryFlag_ff, carry_ff};
                        ADR_DIR_A:    datRd_ff <= {24'h000000, dirA_ff};
                        ADR_DIR_B:    datRd_ff <= {24'h000000, dirB_ff};
                        ADR_DIR_C:    datRd_ff <= {24'h000000, dirC_ff};
                        ADR_WATCHDOG: datRd_ff <= {16'h0000, prescaler_ff, watchdogCounter_ff};
                        default:      datRd_ff <= 32'h0000_0000;
                    endcase
                end
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            oscStop <= 1'b0;
        end else begin
            oscStop <= (power_ff == CAS_ASLEEP) | goSleep;                  // [RULE9]
        end
    end

    assign ack            = ack_ff;
    assign datRd          = datRd_ff;
    assign portADirection = dirA_ff;
    assign portBDirection = dirB_ff;
    assign portCDirection = dirC_ff;

endmodule

/* rtl/cas_pkg.sv */
// Constants, opcodes and register map of the instruction execution block.
// Assumes a classic Wishbone master with 32-bit data and byte addresses.
package cas_pkg;

    ////////////////////////////////////////////////////////////////////////////////
    localparam int          ADR_W          = 12;
    localparam logic [11:0] ADR_CMD        = 12'h000;
    localparam logic [11:0] ADR_WORK       = 12'h004;
    localparam logic [11:0] ADR_STATUS     = 12'h008;
    localparam logic [11:0] ADR_WAKE       = 12'h00C;
    localparam logic [11:0] ADR_DIR_A      = 12'h010;
    localparam logic [11:0] ADR_DIR_B      = 12'h014;
    localparam logic [11:0] ADR_DIR_C      = 12'h018;
    localparam logic [11:0] ADR_WATCHDOG   = 12'h01C;
    localparam logic [2:0]  ADR_FILE_REGION = 3'h1;
    localparam int          FILE_DEPTH     = 128;

    ////////////////////////////////////////////////////////////////////////////////
    localparam int CMD_OP_LSB   = 12;
    localparam int CMD_DEST_BIT = 8;

    localparam logic [3:0] OP_ROTATE_RIGHT_CARRY    = 4'h1;
    localparam logic [3:0] OP_LITERAL_MINUS_WORK    = 4'h2;
    localparam logic [3:0] OP_REG_MINUS_WORK        = 4'h3;
    localparam logic [3:0] OP_REG_MINUS_WORK_BORROW = 4'h4;
    localparam logic [3:0] OP_SLEEP                 = 4'h5;
    localparam logic [3:0] OP_NIBBLE_SWAP           = 4'h6;
    localparam logic [3:0] OP_LOAD_PORT_DIRECTION   = 4'h7;
    localparam logic [3:0] OP_LITERAL_XOR           = 4'h8;
    localparam logic [3:0] OP_REG_XOR               = 4'h9;

    localparam logic [7:0] DIR_SEL_A = 8'h05;
    localparam logic [7:0] DIR_SEL_B = 8'h06;
    localparam logic [7:0] DIR_SEL_C = 8'h07;

    ////////////////////////////////////////////////////////////////////////////////
    localparam int ST_CARRY   = 0;
    localparam int ST_DIGIT   = 1;
    localparam int ST_ZERO    = 2;
    localparam int ST_PD_N    = 3;
    localparam int ST_TO_N    = 4;
    localparam int ST_ASLEEP  = 5;
    localparam int WAKE_BIT   = 0;

    localparam logic [7:0] RST_WORK      = 8'h00;
    localparam logic [7:0] RST_FILE      = 8'h00;
    localparam logic [7:0] RST_DIR       = 8'hFF;
    localparam logic [7:0] WATCHDOG_CLR  = 8'h00;
    localparam logic [7:0] PRESCALER_CLR = 8'h00;
    localparam logic [7:0] PRESCALER_TOP = 8'hFF;

    typedef enum logic {CAS_AWAKE, CAS_ASLEEP} cas_power_t;

endpackage

/* verification/cas_exec_core_monitor.sv */
// Checker for the execution block: bus answer, sleep stop and direction outputs.
// Assumes it sees only the top module's ports; attached by the bind at the foot.
`timescale 1ns/1ps

module cas_exec_core_monitor
    import cas_pkg::*;
(
    input wire logic                      mclk,
    input wire logic                      rst,
    input wire logic                      cyc,
    input wire logic                      stb,
    input wire logic                      we,
    input wire logic [cas_pkg::ADR_W-1:0] adr,
    input wire logic [3:0]                sel,
    input wire logic [31:0]               datWr,
    input wire logic [31:0]               datRd,
    input wire logic                      ack,
    input wire logic [7:0]                portADirection,
    input wire logic [7:0]                portBDirection,
    input wire logic [7:0]                portCDirection,
    input wire logic                      oscStop
);
    ////////////////////////////////////////////////////////////////////////////////
    logic take, cmdTake, dirCmd, sleepTake, wakeTake;
    assign take      = cyc && stb && !ack;
    assign cmdTake   = take && we && adr == ADR_CMD && sel[1:0] == 2'h3;
    assign dirCmd    = cmdTake && datWr[15:12] == OP_LOAD_PORT_DIRECTION;
    assign sleepTake = cmdTake && datWr[15:12] == OP_SLEEP;
    assign wakeTake  = take && we && adr == ADR_WAKE && sel[0] && datWr[0];

    default clocking @(posedge mclk); endclocking
    default disable iff (rst);

    ////////////////////////////////////////////////////////////////////////////////
    a_ack_one_late: assert property (take |=> ack)
        else $error("access not answered one cycle after it was taken");
    a_ack_one_wide: assert property (ack |=> !ack)
        else $error("ack stayed high two cycles");
    a_dir_a_hold: assert property (!(dirCmd && datWr[7:0] == DIR_SEL_A) |=> $stable(portADirection))
        else $error("port A direction changed without its load");
    a_dir_b_hold: assert property (!(dirCmd && datWr[7:0] == DIR_SEL_B) |=> $stable(portBDirection))
        else $error("port B direction changed without its load");
    a_dir_c_hold: assert property (!(dirCmd && datWr[7:0] == DIR_SEL_C) |=> $stable(portCDirection))
        else $error("port C direction changed without its load");
    a_sleep_stops: assert property (sleepTake && !oscStop |-> ##[1:2] oscStop)
        else $error("sleep did not stop the oscillator");
    a_stop_holds: assert property (oscStop && !wakeTake && !$past(wakeTake) |=> oscStop)
        else $error("oscillator restarted without a wake");
    a_stop_no_rise: assert property (!oscStop && !sleepTake && !$past(sleepTake) |=> !oscStop)
        else $error("oscillator stopped without sleep");
    a_wake_runs: assert property (wakeTake && oscStop |-> ##[1:2] !oscStop)
        else $error("wake did not restart the oscillator");
endmodule

bind cas_exec_core cas_exec_core_monitor u_mon (.mclk(mclk), .rst(rst), .cyc(cyc), .stb(stb),
    .we(we), .adr(adr), .sel(sel), .datWr(datWr), .datRd(datRd), .ack(ack),
    .portADirection(portADirection), .portBDirection(portBDirection),
    .portCDirection(portCDirection), .oscStop(oscStop));

/* verification/cas_exec_core_tb.sv */
// Self-checking bench: Wishbone tasks, instruction table, direction loads, sleep.
// Assumes cas_pkg and cas_exec_core are compiled first.
`timescale 1ns/1ps

module cas_exec_core_tb;
    import cas_pkg::*;
    logic        mclk = 1'b0, rst = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
    logic [11:0] adr = 12'h000;
    logic [3:0]  sel = 4'hF;
    logic [31:0] datWr = 32'h0, datRd, q;
    logic        ack, oscStop, pdN = 1'b1;
    logic [7:0]  portADirection, portBDirection, portCDirection;
    logic [7:0]  dirs [5:7];
    int          fails = 0, nChecks = 0, i;

    cas_exec_core uut (.mclk(mclk), .rst(rst), .cyc(cyc), .stb(stb), .we(we), .adr(adr),
        .sel(sel), .datWr(datWr), .datRd(datRd), .ack(ack), .portADirection(portADirection),
        .portBDirection(portBDirection), .portCDirection(portCDirection), .oscStop(oscStop));

    always #12.5 mclk = ~mclk;

    ////////////////////////////////////////////////////////////////////////////////
    task wrap_up;
        if (fails == 0 && nChecks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask

    task check(input logic [31:0] seen, input logic [31:0] exp);
        nChecks++;
        if (seen !== exp) begin
            fails++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Holds the request until ack is sampled; read data taken at that edge only
    task access(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge mclk);
        cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; datWr <= d;
        n = 0;
        do begin @(posedge mclk); n++; end while (ack !== 1'b1 && n < 20);
        q = datRd;
        cyc <= 1'b0; stb <= 1'b0;
        if (n >= 20) begin
            fails++;
            $display("[ERR] %0t bus answer missing", $time);
            wrap_up;
        end
    endtask

    task wait_stop(input logic lvl);
        for (i = 0; i < 8 && oscStop !== lvl; i++) @(posedge mclk);
        check({31'h0, oscStop}, {31'h0, lvl});
    endtask

    // One instruction from preset operands, then work, file and flags read back
    task exec(input logic [3:0] op, input logic d, input logic [7:0] k, fv, w, st);
        logic [7:0]  r, src;
        logic [11:0] fa;
        logic [8:0]  t;
        logic [4:0]  n;
        logic        c, dc, z, lit, b;
        lit = (op == OP_LITERAL_MINUS_WORK) || (op == OP_LITERAL_XOR);
        fa = {3'h1, lit ? 7'h03 : k[6:0], 2'h0};
        access(1'b1, fa, {24'h0, fv});
        access(1'b1, ADR_WORK, {24'h0, w});
        access(1'b1, ADR_STATUS, {24'h0, st});
        c = st[0]; dc = st[1]; z = st[2];
        src = lit ? k : fv;
        b = (op == OP_REG_MINUS_WORK_BORROW) ? !c : 1'b0;
        t = {1'b0, src} - {1'b0, w} - {8'h0, b};
        n = {1'b0, src[3:0]} - {1'b0, w[3:0]} - {4'h0, b};
        r = t[7:0];
        case (op)
            OP_ROTATE_RIGHT_CARRY: begin r = {c, fv[7:1]}; c = fv[0]; end
            OP_NIBBLE_SWAP: r = {fv[3:0], fv[7:4]};
            OP_LITERAL_XOR, OP_REG_XOR: begin r = w ^ src; z = (r == 8'h00); end
            default: begin c = !t[8]; dc = !n[4]; z = (r == 8'h00); end
        endcase
        access(1'b1, ADR_CMD, {16'h0, op, 3'h0, d, k});
        access(1'b0, ADR_WORK, 32'h0);
        check(q, {24'h0, (lit || !d) ? r : w});
        access(1'b0, fa, 32'h0);
        check(q, {24'h0, (!lit && d) ? r : fv});
        access(1'b0, ADR_STATUS, 32'h0);
        check(q, {26'h0, 2'h1, pdN, z, dc, c});
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (8) @(posedge mclk);
        rst <= 1'b0;
        check({24'h0, portADirection}, {24'h0, RST_DIR});
        access(1'b0, ADR_STATUS, 32'h0);
        check(q, 32'h18);
        access(1'b0, 12'h100, 32'h0);
        check(q, 32'h0);
        exec(OP_ROTATE_RIGHT_CARRY, 1'b1, 8'h7F, 8'h81, 8'h00, 8'h05);
        exec(OP_ROTATE_RIGHT_CARRY, 1'b0, 8'h03, 8'hC0, 8'h11, 8'h01);
        exec(OP_LITERAL_MINUS_WORK, 1'b0, 8'h5A, 8'h00, 8'h5A, 8'h00);
        exec(OP_LITERAL_MINUS_WORK, 1'b0, 8'h20, 8'h00, 8'h31, 8'h07);
        exec(OP_LITERAL_MINUS_WORK, 1'b0, 8'h3F, 8'h00, 8'h21, 8'h00);
        exec(OP_REG_MINUS_WORK, 1'b1, 8'h03, 8'h18, 8'h09, 8'h00);
        exec(OP_REG_MINUS_WORK, 1'b0, 8'h00, 8'h10, 8'h20, 8'h07);
        exec(OP_REG_MINUS_WORK_BORROW, 1'b1, 8'h03, 8'h40, 8'h40, 8'h00);
        exec(OP_REG_MINUS_WORK_BORROW, 1'b0, 8'h03, 8'h41, 8'h40, 8'h01);
        exec(OP_REG_MINUS_WORK_BORROW, 1'b0, 8'h03, 8'h41, 8'h40, 8'h00);
        exec(OP_NIBBLE_SWAP, 1'b1, 8'h03, 8'hA5, 8'h00, 8'h07);
        exec(OP_NIBBLE_SWAP, 1'b0, 8'h03, 8'hF0, 8'h33, 8'h00);
        exec(OP_LITERAL_XOR, 1'b0, 8'hFF, 8'h00, 8'hFF, 8'h03);
        exec(OP_LITERAL_XOR, 1'b0, 8'h0F, 8'h00, 8'hF0, 8'h04);
        exec(OP_REG_XOR, 1'b1, 8'h03, 8'h3C, 8'h3C, 8'h00);
        exec(OP_REG_XOR, 1'b0, 8'h03, 8'h3C, 8'hC3, 8'h07);
        // Operands 4 and 8 bracket the legal range and must change nothing
        dirs[5] = RST_DIR; dirs[6] = RST_DIR; dirs[7] = RST_DIR;
        for (int s = 4; s <= 8; s++) begin
            access(1'b1, ADR_WORK, 32'h30 + s);
            access(1'b1, ADR_CMD, {16'h0, OP_LOAD_PORT_DIRECTION, 4'h0, 8'(s)});
            if (s >= 5 && s <= 7) dirs[s] = 8'h30 + 8'(s);
            check({24'h0, portADirection}, {24'h0, dirs[5]});
            check({24'h0, portBDirection}, {24'h0, dirs[6]});
            check({24'h0, portCDirection}, {24'h0, dirs[7]});
        end
        access(1'b1, ADR_DIR_A, 32'h0);
        access(1'b0, ADR_DIR_A, 32'h0);
        check(q, {24'h0, dirs[5]});
        access(1'b1, ADR_STATUS, 32'h0);
        access(1'b1, ADR_CMD, {16'h0, OP_SLEEP, 12'h000});
        pdN = 1'b0;
        wait_stop(1'b1);
        access(1'b0, ADR_STATUS, 32'h0);
        check(q, 32'h30);
        access(1'b0, ADR_WATCHDOG, 32'h0);
        check({24'h0, q[7:0]}, {24'h0, WATCHDOG_CLR});
        // Prescaler restarts from zero, so only a few cycles have passed
        check({31'h0, q[15:8] < 8'h10}, 32'h1);
        // Commands while halted are answered but must not run
        access(1'b1, ADR_CMD, {16'h0, OP_LITERAL_XOR, 12'h0FF});
        access(1'b0, ADR_WORK, 32'h0);
        check(q, 32'h38);
        access(1'b1, ADR_WAKE, 32'h1);
        wait_stop(1'b0);
        access(1'b0, ADR_STATUS, 32'h0);
        check(q, 32'h10);
        wrap_up;
    end
endmodule
